// ==== rtl/cdpd_duty.sv ====
// Output duty-cycle figure of one channel as numerator over denominator
// Assumes all inputs are register fields on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "cdpd_regs.svh"

module cdpd_duty
	import cdpd_pkg::*;
(
	input  wire logic        dcc_off,
	input  wire logic        vco_used,
	input  wire logic [2:0]  vdiv,
	input  wire logic        byp1,
	input  wire logic        byp2,
	input  wire logic [3:0]  n1,
	input  wire logic [3:0]  m1,
	input  wire logic [3:0]  n2,
	input  wire logic [3:0]  m2,
	output logic [15:0]      num,
	output logic [15:0]      den,
	output cdpd_duty_cls_t   cls
);

	logic [15:0] a;
	logic [15:0] b;
	logic [15:0] ma;
	logic [15:0] mb;
	logic        odd1;
	logic        odd2;
	logic        v3;
	logic        v5;

	always_comb begin
		a    = {12'h000, n1};
		b    = {12'h000, n2};
		ma   = {12'h000, m1};
		mb   = {12'h000, m2};
		odd1 = n1[0] ^ m1[0];
		odd2 = n2[0] ^ m2[0];
		v3   = vco_used && (vdiv == `CDPD_VDIV_ODD3);
		v5   = vco_used && (vdiv == `CDPD_VDIV_ODD5);
		num  = 16'h0001;
		den  = 16'h0002;
		cls  = DC_EXACT;
		if (dcc_off) begin
			if (byp1 && byp2) begin
				if (v3) begin
					den = 16'h0003;
				end else if (v5) begin
					num = 16'h0002;
					den = 16'h0005;
				end else if (!vco_used) begin
					cls = DC_INPUT;
				end
			end else if (byp2) begin
				num = a + 16'h0001;
				den = a + ma + 16'h0002;
			end else begin
				num = b + 16'h0001;
				den = b + mb + 16'h0002;
			end
		end else if (vco_used) begin
			if (byp1 && byp2) begin
				if (v3) begin
					den = 16'h0003;
					cls = DC_PLUS_X;
				end else if (v5) begin
					num = 16'h0002;
					den = 16'h0005;
					cls = DC_PLUS_X;
				end
			end else if (byp2) begin
				if (odd1 && v3) begin
					num = 16'h0003 * a + 16'h0004;
					den = 16'h0006 * a + 16'h0009;
					cls = DC_PLUS_X;
				end else if (odd1 && v5) begin
					num = 16'h0005 * a + 16'h0007;
					den = 16'h000a * a + 16'h000f;
					cls = DC_PLUS_X;
				end
			end else if (odd1 && odd2 && v3) begin
				num = 16'h0006 * a * b + 16'h0009 * a + 16'h0009 * b + 16'h000d;
				den = 16'h0003 * (16'h0002 * a + 16'h0003) * (16'h0002 * b + 16'h0003);
				cls = DC_PLUS_X;
			end else if (odd1 && odd2 && v5) begin
				num = 16'h000a * a * b + 16'h000f * a + 16'h000f * b + 16'h0016;
				den = 16'h0005 * (16'h0002 * a + 16'h0003) * (16'h0002 * b + 16'h0003);
				cls = DC_PLUS_X;
			end
		end else begin
			if (byp1 && byp2) begin
				cls = DC_INPUT;
			end else if (byp2) begin
				if (odd1) begin
					num = a + 16'h0001;
					den = 16'h0002 * a + 16'h0003;
					cls = DC_PLUS_X;
				end
			end else if (odd1 && odd2) begin
				num = 16'h0002 * a * b + 16'h0003 * a + 16'h0003 * b + 16'h0004;
				den = (16'h0002 * a + 16'h0003) * (16'h0002 * b + 16'h0003);
				cls = DC_PLUS_X;
			end
		end
	end

endmodule

`default_nettype wire

// ==== rtl/cdpd_pkg.sv ====
// Types and shared helpers of the cascaded divider block
// Assumes the register header is on the include path
`default_nettype none
`include "cdpd_regs.svh"

package cdpd_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_HOLD  = 4'h1,
		ST_DELAY = 4'h2,
		ST_HIGH  = 4'h4,
		ST_LOW   = 4'h8
	} cdpd_stage_st_t;

	typedef enum logic [1:0] {
		DC_EXACT  = 2'h0,
		DC_INPUT  = 2'h1,
		DC_PLUS_X = 2'h2
	} cdpd_duty_cls_t;

	typedef enum logic [3:0] {
		SEL_NONE, SEL_CNT1, SEL_PHASE, SEL_CNT2, SEL_START, SEL_DFIX,
		SEL_CTRL, SEL_DLY, SEL_DUTY, SEL_STAT
	} cdpd_sel_t;

	typedef struct packed {
		cdpd_stage_st_t st;
		logic [4:0]     cnt;
		logic           lvl;
		logic           pulse;
	} cdpd_stage_state_t;

	typedef struct packed {
		logic             ph_wr;
		cdpd_sel_t        ph_sel;
		logic             ph_ch;
		logic [1:0][7:0]  cnt1;
		logic [1:0][7:0]  phase;
		logic [1:0][7:0]  cnt2;
		logic [1:0][7:0]  start;
		logic [1:0]       dfix;
		logic             vco_used;
		logic [2:0]       vdiv;
		logic             soft_sync;
		logic [31:0]      rdata;
		logic             sync_m;
		logic             sync_s;
		logic [2:0]       vcnt;
		logic             vlvl;
		logic [1:0]       out;
	} cdpd_top_state_t;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] cdpd_phase_val(input logic sh, input logic [3:0] po);
		return (sh ? `CDPD_SH_WEIGHT : 5'h00) + {1'b0, po};
	endfunction

	function automatic logic [4:0] cdpd_delay_cycles(input logic [4:0] phv, input logic [3:0] low);
		if (phv < `CDPD_SH_WEIGHT) begin
			return phv;
		end
		return phv - `CDPD_SH_WEIGHT + {1'b0, low} + 5'h01;
	endfunction

endpackage

`default_nettype wire

// ==== rtl/cdpd_regs.svh ====
// Register indices, field positions, reset values and fixed counts of the cascaded divider block
// Assumes byte address = 4 x index on a 32-bit AHB-Lite bus
`ifndef CDPD_REGS_SVH
`define CDPD_REGS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define CDPD_IDX_CH3_CNT1    10'h199
`define CDPD_IDX_CH3_PHASE   10'h19a
`define CDPD_IDX_CH3_CNT2    10'h19b
`define CDPD_IDX_CH3_START   10'h19c
`define CDPD_IDX_CH3_DFIX    10'h19d
`define CDPD_IDX_CH4_CNT1    10'h19e
`define CDPD_IDX_CH4_PHASE   10'h19f
`define CDPD_IDX_CH4_CNT2    10'h1a0
`define CDPD_IDX_CH4_START   10'h1a1
`define CDPD_IDX_CH4_DFIX    10'h1a2
`define CDPD_IDX_CTRL        10'h1f0
`define CDPD_IDX_CH3_DLY     10'h1f1
`define CDPD_IDX_CH3_DUTY    10'h1f2
`define CDPD_IDX_CH4_DLY     10'h1f3
`define CDPD_IDX_CH4_DUTY    10'h1f4
`define CDPD_IDX_STAT        10'h1f5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CDPD_SH1_BIT         0
`define CDPD_SH2_BIT         1
`define CDPD_BYP1_BIT        4
`define CDPD_BYP2_BIT        5
`define CDPD_DFIX_BIT        0
`define CDPD_CTRL_VCO_BIT    0
`define CDPD_CTRL_VDIV_LSB   4
`define CDPD_CTRL_VDIV_MSB   6
`define CDPD_CTRL_SYNC_BIT   8

// ----------------------------------------------------------------
// Reset values and fixed counts
// ----------------------------------------------------------------
`define CDPD_RST_BYTE        8'h00
`define CDPD_RST_VDIV        3'h2
`define CDPD_SH_WEIGHT       5'h10
`define CDPD_VDIV_MIN        3'h2
`define CDPD_VDIV_MAX        3'h6
`define CDPD_VDIV_ODD3       3'h3
`define CDPD_VDIV_ODD5       3'h5

`endif

// ==== rtl/cdpd_stage.sv ====
// One programmable divider stage with start level and coarse phase delay
// Assumes tick_in is a one-cycle input-clock pulse from the same clock domain
`timescale 1ns/10ps
`default_nettype none

module cdpd_stage
	import cdpd_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       sync_hold,
	input  wire logic       tick_in,
	input  wire logic       in_lvl,
	input  wire logic       bypass,
	input  wire logic       start_high,
	input  wire logic [3:0] phase_field,
	input  wire logic [3:0] low_cnt,
	input  wire logic [3:0] high_cnt,
	output logic            lvl,
	output logic            tick_out
);

	cdpd_stage_state_t r;
	cdpd_stage_state_t next_r;
	logic [4:0]        dly;

	function automatic cdpd_stage_state_t start_run(input logic sh);
		cdpd_stage_state_t s;
		s.st    = sh ? ST_HIGH : ST_LOW;
		s.cnt   = 5'h00;
		s.lvl   = sh;
		s.pulse = sh;
		return s;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r       = r;
		next_r.pulse = 1'b0;
		dly          = cdpd_delay_cycles(cdpd_phase_val(start_high, phase_field), low_cnt);
		case (r.st)
			ST_HOLD: begin
				next_r.lvl = start_high;
				next_r.cnt = 5'h00;
				if (!sync_hold) begin
					if (dly == 5'h00) begin
						next_r = start_run(start_high);
					end else begin
						next_r.st  = ST_DELAY;
						next_r.cnt = dly;
					end
				end
			end
			ST_DELAY: begin
				if (tick_in) begin
					if (r.cnt == 5'h01) begin
						next_r = start_run(start_high);
					end else begin
						next_r.cnt = r.cnt - 5'h01;
					end
				end
			end
			ST_HIGH: begin
				if (tick_in) begin
					if (r.cnt == {1'b0, high_cnt}) begin
						next_r.st  = ST_LOW;
						next_r.cnt = 5'h00;
						next_r.lvl = 1'b0;
					end else begin
						next_r.cnt = r.cnt + 5'h01;
					end
				end
			end
			ST_LOW: begin
				if (tick_in) begin
					if (r.cnt == {1'b0, low_cnt}) begin
						next_r.st    = ST_HIGH;
						next_r.cnt   = 5'h00;
						next_r.lvl   = 1'b1;
						next_r.pulse = 1'b1;
					end else begin
						next_r.cnt = r.cnt + 5'h01;
					end
				end
			end
			default: begin
				next_r.st  = ST_HOLD;
				next_r.cnt = 5'h00;
				next_r.lvl = 1'b0;
			end
		endcase
		if (sync_hold) begin
			next_r.st    = ST_HOLD;
			next_r.cnt   = 5'h00;
			next_r.lvl   = start_high;
			next_r.pulse = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '{st: ST_HOLD, cnt: 5'h00, lvl: 1'b0, pulse: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	// Bypassed stage divides by one
	assign lvl      = bypass ? in_lvl : r.lvl;
	assign tick_out = bypass ? tick_in : r.pulse;

endmodule

`default_nettype wire

// ==== rtl/cdpd_top.sv ====
// Two cascaded-divider channels with coarse phase delay and duty figures, AHB-Lite register slave
// Assumes hclk is the channel divider input clock and sync_n is an asynchronous pin
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "cdpd_regs.svh"

module cdpd_top
	import cdpd_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        sync_n,
	output logic             ch3_clk_out,
	output logic             ch4_clk_out
);

	cdpd_top_state_t  r;
	cdpd_top_state_t  next_r;

	logic             sync_hold;
	logic             ch_tick;
	logic             in_lvl;
	logic [2:0]       vdiv_eff;
	logic             take;
	cdpd_sel_t        a_sel;
	logic             a_ch;
	logic [1:0]       s1_lvl;
	logic [1:0]       s1_tick;
	logic [1:0]       s2_lvl;
	logic [1:0][15:0] dly_tot;
	logic [1:0][15:0] duty_num;
	logic [1:0][15:0] duty_den;
	cdpd_duty_cls_t   duty_cls [2];

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic cdpd_sel_t decode_sel(input logic [31:0] addr);
		logic [9:0] idx;
		idx        = addr[11:2];
		decode_sel = SEL_NONE;
		if (addr[31:12] == 20'h00000) begin
			case (idx)
				`CDPD_IDX_CH3_CNT1:  decode_sel = SEL_CNT1;
				`CDPD_IDX_CH3_PHASE: decode_sel = SEL_PHASE;
				`CDPD_IDX_CH3_CNT2:  decode_sel = SEL_CNT2;
				`CDPD_IDX_CH3_START: decode_sel = SEL_START;
				`CDPD_IDX_CH3_DFIX:  decode_sel = SEL_DFIX;
				`CDPD_IDX_CH4_CNT1:  decode_sel = SEL_CNT1;
				`CDPD_IDX_CH4_PHASE: decode_sel = SEL_PHASE;
				`CDPD_IDX_CH4_CNT2:  decode_sel = SEL_CNT2;
				`CDPD_IDX_CH4_START: decode_sel = SEL_START;
				`CDPD_IDX_CH4_DFIX:  decode_sel = SEL_DFIX;
				`CDPD_IDX_CTRL:      decode_sel = SEL_CTRL;
				`CDPD_IDX_CH3_DLY:   decode_sel = SEL_DLY;
				`CDPD_IDX_CH3_DUTY:  decode_sel = SEL_DUTY;
				`CDPD_IDX_CH4_DLY:   decode_sel = SEL_DLY;
				`CDPD_IDX_CH4_DUTY:  decode_sel = SEL_DUTY;
				`CDPD_IDX_STAT:      decode_sel = SEL_STAT;
				default:             decode_sel = SEL_NONE;
			endcase
		end
	endfunction

	function automatic logic decode_ch(input logic [31:0] addr);
		logic [9:0] idx;
		idx       = addr[11:2];
		decode_ch = 1'b0;
		case (idx)
			`CDPD_IDX_CH4_CNT1,
			`CDPD_IDX_CH4_PHASE,
			`CDPD_IDX_CH4_CNT2,
			`CDPD_IDX_CH4_START,
			`CDPD_IDX_CH4_DFIX,
			`CDPD_IDX_CH4_DLY,
			`CDPD_IDX_CH4_DUTY: decode_ch = 1'b1;
			default:            decode_ch = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Input clock source and sync
	// ----------------------------------------------------------------
	always_comb begin
		vdiv_eff = r.vdiv;
		if (r.vdiv < `CDPD_VDIV_MIN) begin
			vdiv_eff = `CDPD_VDIV_MIN;
		end else if (r.vdiv > `CDPD_VDIV_MAX) begin
			vdiv_eff = `CDPD_VDIV_MAX;
		end
	end

	assign ch_tick   = r.vco_used ? (r.vcnt == (vdiv_eff - 3'h1)) : 1'b1;
	assign in_lvl    = r.vco_used ? r.vlvl : 1'b1;
	assign sync_hold = !r.sync_s || r.soft_sync;

	// ----------------------------------------------------------------
	// Bus address phase
	// ----------------------------------------------------------------
	assign take      = hsel && hready && htrans[1] && (hsize == 3'h2);
	assign a_sel     = decode_sel(haddr);
	assign a_ch      = decode_ch(haddr);

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			logic        byp1;
			logic        byp2;
			logic        sh1;
			logic        sh2;
			logic [3:0]  po1;
			logic [3:0]  po2;
			logic [3:0]  low1;
			logic [3:0]  high1;
			logic [3:0]  low2;
			logic [3:0]  high2;
			logic [4:0]  c1;
			logic [4:0]  c2;
			logic [15:0] t1;
			logic [15:0] d1;

			// ----------------------------------------------------------------
			// Field views
			// ----------------------------------------------------------------
			assign byp1  = r.start[ch][`CDPD_BYP1_BIT];
			assign byp2  = r.start[ch][`CDPD_BYP2_BIT];
			assign sh1   = r.start[ch][`CDPD_SH1_BIT];
			assign sh2   = r.start[ch][`CDPD_SH2_BIT];
			assign po1   = r.phase[ch][3:0];
			assign po2   = r.phase[ch][7:4];
			assign low1  = r.cnt1[ch][7:4];
			assign high1 = r.cnt1[ch][3:0];
			assign low2  = r.cnt2[ch][7:4];
			assign high2 = r.cnt2[ch][3:0];

			// ----------------------------------------------------------------
			// Stage chain
			// ----------------------------------------------------------------
			cdpd_stage u_s1 (
				.hclk        (hclk),
				.hresetn     (hresetn),
				.sync_hold   (sync_hold),
				.tick_in     (ch_tick),
				.in_lvl      (in_lvl),
				.bypass      (byp1),
				.start_high  (sh1),
				.phase_field (po1),
				.low_cnt     (low1),
				.high_cnt    (high1),
				.lvl         (s1_lvl[ch]),
				.tick_out    (s1_tick[ch])
			);

			cdpd_stage u_s2 (
				.hclk        (hclk),
				.hresetn     (hresetn),
				.sync_hold   (sync_hold),
				.tick_in     (s1_tick[ch]),
				.in_lvl      (s1_lvl[ch]),
				.bypass      (byp2),
				.start_high  (sh2),
				.phase_field (po2),
				.low_cnt     (low2),
				.high_cnt    (high2),
				.lvl         (s2_lvl[ch]),
				.tick_out    ()
			);

			// ----------------------------------------------------------------
			// Duty figure
			// ----------------------------------------------------------------
			cdpd_duty u_duty (
				.dcc_off  (r.dfix[ch]),
				.vco_used (r.vco_used),
				.vdiv     (vdiv_eff),
				.byp1     (byp1),
				.byp2     (byp2),
				.n1       (high1),
				.m1       (low1),
				.n2       (high2),
				.m2       (low2),
				.num      (duty_num[ch]),
				.den      (duty_den[ch]),
				.cls      (duty_cls[ch])
			);

			// ----------------------------------------------------------------
			// Coarse delay in hclk cycles
			// ----------------------------------------------------------------
			always_comb begin
				c1 = byp1 ? 5'h00 :
					cdpd_delay_cycles(cdpd_phase_val(sh1, po1), low1);
				c2 = byp2 ? 5'h00 :
					cdpd_delay_cycles(cdpd_phase_val(sh2, po2), low2);
				t1 = r.vco_used ? {13'h0000, vdiv_eff} : 16'h0001;
				d1 = byp1 ? 16'h0001 : {12'h000, high1} + {12'h000, low1} + 16'h0002;
				dly_tot[ch] = {11'h000, c1} * t1 + {11'h000, c2} * d1 * t1;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	function automatic logic [31:0] rd_word(input cdpd_top_state_t s, input cdpd_sel_t sel, input logic c);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (sel)
			SEL_CNT1:  w[7:0] = s.cnt1[c];
			SEL_PHASE: w[7:0] = s.phase[c];
			SEL_CNT2:  w[7:0] = s.cnt2[c];
			SEL_START: begin
				w[`CDPD_SH1_BIT]  = s.start[c][`CDPD_SH1_BIT];
				w[`CDPD_SH2_BIT]  = s.start[c][`CDPD_SH2_BIT];
				w[`CDPD_BYP1_BIT] = s.start[c][`CDPD_BYP1_BIT];
				w[`CDPD_BYP2_BIT] = s.start[c][`CDPD_BYP2_BIT];
			end
			SEL_DFIX:  w[`CDPD_DFIX_BIT] = s.dfix[c];
			SEL_CTRL: begin
				w[`CDPD_CTRL_VCO_BIT]                       = s.vco_used;
				w[`CDPD_CTRL_VDIV_MSB:`CDPD_CTRL_VDIV_LSB] = s.vdiv;
				w[`CDPD_CTRL_SYNC_BIT]                      = s.soft_sync;
			end
			SEL_DLY:   w[15:0] = dly_tot[c];
			SEL_DUTY:  w = {duty_den[c], duty_num[c]};
			SEL_STAT:  w[6:0] = {s2_lvl[1], s2_lvl[0], sync_hold, duty_cls[1], duty_cls[0]};
			default:   w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r        = r;
		next_r.sync_m = sync_n;
		next_r.sync_s = r.sync_m;
		next_r.out    = s2_lvl;

		// ----------------------------------------------------------------
		// Input divider
		// ----------------------------------------------------------------
		if (r.vco_used) begin
			next_r.vcnt = ch_tick ? 3'h0 : r.vcnt + 3'h1;
		end else begin
			next_r.vcnt = 3'h0;
		end
		next_r.vlvl = (next_r.vcnt < {1'b0, vdiv_eff[2:1]});

		// ----------------------------------------------------------------
		// Data phase write
		// ----------------------------------------------------------------
		if (r.ph_wr) begin
			case (r.ph_sel)
				SEL_CNT1:  next_r.cnt1[r.ph_ch]  = hwdata[7:0];
				SEL_PHASE: next_r.phase[r.ph_ch] = hwdata[7:0];
				SEL_CNT2:  next_r.cnt2[r.ph_ch]  = hwdata[7:0];
				SEL_START: next_r.start[r.ph_ch] = hwdata[7:0] & 8'h33;
				SEL_DFIX:  next_r.dfix[r.ph_ch]  = hwdata[`CDPD_DFIX_BIT];
				SEL_CTRL: begin
					next_r.vco_used  = hwdata[`CDPD_CTRL_VCO_BIT];
					next_r.vdiv      = hwdata[`CDPD_CTRL_VDIV_MSB:`CDPD_CTRL_VDIV_LSB];
					next_r.soft_sync = hwdata[`CDPD_CTRL_SYNC_BIT];
				end
				default: begin
					next_r.vdiv = next_r.vdiv;
				end
			endcase
		end

		// ----------------------------------------------------------------
		// Address phase
		// ----------------------------------------------------------------
		next_r.ph_wr  = take && hwrite;
		next_r.ph_sel = take ? a_sel : SEL_NONE;
		next_r.ph_ch  = a_ch;
		next_r.rdata  = (take && !hwrite) ? rd_word(next_r, a_sel, a_ch) : 32'h0000_0000;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '{
				ph_wr:     1'b0,
				ph_sel:    SEL_NONE,
				ph_ch:     1'b0,
				cnt1:      {2{`CDPD_RST_BYTE}},
				phase:     {2{`CDPD_RST_BYTE}},
				cnt2:      {2{`CDPD_RST_BYTE}},
				start:     {2{`CDPD_RST_BYTE}},
				dfix:      2'h0,
				vco_used:  1'b0,
				vdiv:      `CDPD_RST_VDIV,
				soft_sync: 1'b0,
				rdata:     32'h0000_0000,
				sync_m:    1'b0,
				sync_s:    1'b0,
				vcnt:      3'h0,
				vlvl:      1'b0,
				out:       2'h0
			};
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hreadyout   = 1'b1;
	assign hresp       = 1'b0;
	assign hrdata      = r.rdata;
	assign ch3_clk_out = r.out[0];
	assign ch4_clk_out = r.out[1];

endmodule

`default_nettype wire

// ==== sim/cdpd_sva.sv ====
// Port checks of the cascaded divider top
// Assumes it is bound into cdpd_top, one clock domain
`timescale 1ns/10ps
`default_nettype none

module cdpd_sva (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        sync_n,
	input wire logic        ch3_clk_out,
	input wire logic        ch4_clk_out
);
	wire rd_req = hsel & hready & htrans[1] & ~hwrite;

	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// ----
	// Sequences
	// ----
	sequence rd_word;
		rd_req && hsize == 3'h2;
	endsequence
	sequence sync_held;
		!sync_n [*6];
	endsequence

	a_ready_high: assert property (hreadyout == 1'b1)
		else $error("hreadyout low");
	a_okay_resp: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	a_idle_zero: assert property (!rd_req |=> hrdata == 32'h0)
		else $error("hrdata not zero outside read");
	a_nonword_zero: assert property (rd_req && hsize != 3'h2 |=> hrdata == 32'h0)
		else $error("non-word read not zero");
	a_unmapped_zero: assert property (rd_word ##0 haddr[31:12] != 20'h0 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (rd_word ##0 (haddr[31:12] == 20'h0 && haddr[11:2] >= 10'h199 &&
		haddr[11:2] <= 10'h1a2) |=> hrdata[31:8] == 24'h0) else $error("byte register upper bits set");
	a_hold_ch3: assert property (sync_held |-> $stable(ch3_clk_out))
		else $error("ch3 moved in hold");
	a_hold_ch4: assert property (sync_held |-> $stable(ch4_clk_out))
		else $error("ch4 moved in hold");
endmodule

bind cdpd_top cdpd_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
	.hreadyout, .hresp, .hrdata, .sync_n, .ch3_clk_out, .ch4_clk_out);

`default_nettype wire

// ==== sim/test_cascaded_divider_phase_duty.sv ====
// Bench for the cascaded divider top
// Assumes the checker file is compiled with it
`timescale 1ns/10ps
`default_nettype none

module test_cascaded_divider_phase_duty;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic        sync_n = 1'b1;
	wire logic   hreadyout, hresp, ch3_clk_out, ch4_clk_out;
	wire logic [31:0] hrdata;
	logic [31:0] t;
	int          fail_count = 0;
	int          cmp_count = 0;

	always #12.5 hclk = ~hclk;

	cdpd_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
		.hwdata, .hreadyout, .hresp, .hrdata, .sync_n, .ch3_clk_out, .ch4_clk_out);

	// ----
	// Shared tasks
	// ----
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task xfer(input logic w, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= sz;
		do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 50);
		t = hrdata;
		if (n >= 50) begin
			fail_count++;
			stop_test();
		end
	endtask

	task wr(input logic [9:0] i, input logic [31:0] d);
		xfer(1'b1, {20'h0, i, 2'b00}, 3'h2, d);
	endtask

	task rd(input logic [9:0] i);
		xfer(1'b0, {20'h0, i, 2'b00}, 3'h2, 32'h0);
	endtask

	task runlen(input logic v, output int n);
		n = 0;
		while (ch3_clk_out === v && n < 60) begin
			@(posedge hclk);
			#1 n++;
		end
		if (n >= 60) begin
			fail_count++;
			stop_test();
		end
	endtask

	// ----
	// Scenarios
	// ----
	task test_regs;
		logic [9:0] i;
		logic [7:0] m;
		for (int k = 0; k < 8; k++) begin
			i = 10'h199 + 10'(k) + ((k > 3) ? 10'h1 : 10'h0);
			m = (k % 4 == 3) ? 8'h33 : 8'hff;
			rd(i);
			chk(t, 32'h0);
			wr(i, {24'hffffff, 8'ha5 ^ 8'(k)});
			rd(i);
			chk(t, {24'h0, (8'ha5 ^ 8'(k)) & m});
		end
		xfer(1'b0, 32'h0000_1664, 3'h2, 32'h0);
		chk(t, 32'h0);
		xfer(1'b0, 32'h0000_0664, 3'h0, 32'h0);
		chk(t, 32'h0);
		$display("test_regs done");
	endtask

	task test_delay;
		logic [9:0] b;
		wr(10'h1f0, 32'h0);
		for (int c = 0; c < 8; c++) begin
			b = c[2] ? 10'h19e : 10'h199;
			wr(b, 32'h21);
			wr(b + 10'h1, 32'h23);
			wr(b + 10'h2, 32'h10);
			wr(b + 10'h3, {30'h0, c[1:0]});
			rd(c[2] ? 10'h1f3 : 10'h1f1);
			chk(t, (c[0] ? 32'h6 : 32'h3) + (c[1] ? 32'h14 : 32'ha));
		end
		$display("test_delay done");
	endtask

	task automatic test_duty;
		logic [51:0] e [9] = '{52'h31_00_00_30_01_03_2, 52'h51_00_00_30_02_05_2,
			52'h41_00_00_30_01_02_0, 52'h31_21_00_20_07_0f_2, 52'h51_21_00_20_0c_19_2,
			52'h00_21_00_20_02_05_2, 52'h00_21_10_00_07_0f_2, 52'h00_21_11_00_01_02_0,
			52'h00_00_00_30_00_00_1};
		wr(10'h19d, 32'h0);
		for (int k = 0; k < 9; k++) begin
			wr(10'h1f0, {24'h0, e[k][51:44]});
			wr(10'h199, {24'h0, e[k][43:36]});
			wr(10'h19b, {24'h0, e[k][35:28]});
			wr(10'h19c, {24'h0, e[k][27:20]});
			rd(10'h1f5);
			chk({30'h0, t[1:0]}, {28'h0, e[k][3:0]});
			rd(10'h1f2);
			if (e[k][3:0] != 4'h1)
				chk(t, {8'h0, e[k][11:4], 8'h0, e[k][19:12]});
		end
		wr(10'h199, 32'h21);
		wr(10'h19c, 32'h20);
		wr(10'h19d, 32'h1);
		rd(10'h1f2);
		chk(t, 32'h0005_0002);
		rd(10'h1f5);
		chk({28'h0, t[3:0]}, 32'h8);
		rd(10'h1f4);
		chk(t, 32'h000f_0007);
		wr(10'h19d, 32'h0);
		$display("test_duty done");
	endtask

	task test_wave;
		int h;
		int l;
		int n;
		wr(10'h199, 32'h21);
		wr(10'h19a, 32'h0);
		wr(10'h1f0, 32'h0);
		for (int s = 0; s < 2; s++) begin
			wr(10'h19c, s ? 32'h21 : 32'h20);
			if (s)
				sync_n <= 1'b0;
			else
				wr(10'h1f0, 32'h100);
			repeat (8) @(posedge hclk);
			#1 chk({31'h0, ch3_clk_out}, 32'(s));
			chk({31'h0, ch4_clk_out}, 32'h1);
			@(posedge hclk);
			if (s)
				sync_n <= 1'b1;
			else
				wr(10'h1f0, 32'h0);
			runlen(1'b1, n);
			runlen(1'b0, n);
			runlen(1'b1, h);
			runlen(1'b0, l);
			chk(32'(h), 32'h2);
			chk(32'(l), 32'h3);
		end
		$display("test_wave done");
	endtask

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		test_regs();
		test_delay();
		test_duty();
		test_wave();
		stop_test();
	end
endmodule

`default_nettype wire
